// File: logic/kwsr_top.sv
// Key wakeup stop release controller with AHB-Lite register slave
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module kwsr_top #(
	parameter int NPINS = kwsr_pkg::NPINS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic stop_pin,
	input wire logic [NPINS-1:0] wake_pin,
	output logic [NPINS-1:0] pullup_en,
	output logic stop_active,
	output logic irq
);
	import kwsr_pkg::*;

	logic rst_q1_ff, rst_q2_ff, rst_sync_n;
	logic stop_q1_ff, stop_s_ff, stop_d_ff;
	logic [NPINS-1:0] wake_q1_ff, wake_s_ff;
	logic match;

	logic dp_valid_ff, nxt_dp_valid;
	logic dp_write_ff, nxt_dp_write;
	logic [IDX_W-1:0] dp_idx_ff, nxt_dp_idx;
	logic hreadyout_ff, nxt_hreadyout;
	logic [31:0] hrdata_ff, nxt_hrdata;
	logic [7:0] ctl_lower_ff, nxt_ctl_lower;
	logic [7:0] ctl_upper_ff, nxt_ctl_upper;
	logic [7:0] pullup_ff, nxt_pullup;
	logic release_mode_select_ff, nxt_release_mode_select;
	logic [EV_W-1:0] status_ff, nxt_status;
	logic [EV_W-1:0] mask_ff, nxt_mask;
	kwsr_state_t state_ff, nxt_state;
	logic stop_active_ff, nxt_stop_active;
	logic irq_ff, nxt_irq;

	logic acc, wr_go, stop_req, rel_level, stop_rise, release_now;
	logic [EV_W-1:0] events;
	logic [7:0] rdv;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q1_ff <= 1'b0;
			rst_q2_ff <= 1'b0;
		end else begin
			rst_q1_ff <= 1'b1;
			rst_q2_ff <= rst_q1_ff;
		end
	end
	assign rst_sync_n = rst_q2_ff;

	// Pin synchronisers; only the second stage and later are read
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			stop_q1_ff <= 1'b0;
			stop_s_ff <= 1'b0;
			stop_d_ff <= 1'b0;
			wake_q1_ff <= '0;
			wake_s_ff <= '0;
		end else begin
			stop_q1_ff <= stop_pin;
			stop_s_ff <= stop_q1_ff;
			stop_d_ff <= stop_s_ff;
			wake_q1_ff <= wake_pin;
			wake_s_ff <= wake_q1_ff;
		end
	end

	kwsr_wake_match #(
		.NPINS(NPINS)
	) u_match (
		.ctl_lower(ctl_lower_ff),
		.ctl_upper(ctl_upper_ff),
		.wake_pin(wake_s_ff),
		.match(match)
	);

	// Request decode shared by the register groups
	assign acc = hsel & hready & htrans[1];
	assign wr_go = dp_valid_ff & dp_write_ff & hreadyout_ff;
	assign stop_req = wr_go & (dp_idx_ff == IDX_SYSCTL) & hwdata[SYSCTL_STOP_BIT];
	// Stop-release pin has no enable, so it is always a source
	assign rel_level = stop_s_ff | match;
	assign stop_rise = stop_s_ff & ~stop_d_ff;
	// Edge mode: a standing enabled pin match blocks the edge release
	assign release_now = release_mode_select_ff ? rel_level : (stop_rise & ~match);

	// Bus group; reads take one wait state so hrdata can come from a flop
	always_comb begin
		rdv = 8'h00;
		nxt_dp_valid = dp_valid_ff;
		nxt_dp_write = dp_write_ff;
		nxt_dp_idx = dp_idx_ff;
		nxt_hreadyout = 1'b1;
		nxt_hrdata = hrdata_ff;
		if (hreadyout_ff) begin
			nxt_dp_valid = acc;
			nxt_dp_write = hwrite;
			nxt_dp_idx = (haddr[31:IDX_W+2] == '0 && haddr[1:0] == 2'b00) ? haddr[IDX_W+1:2] : IDX_NONE;
			if (acc && !hwrite) begin
				nxt_hreadyout = 1'b0;
			end
		end
		case (dp_idx_ff)
			IDX_LOWER: rdv = ctl_lower_ff;
			IDX_UPPER: rdv = ctl_upper_ff;
			IDX_PULLUP: rdv = pullup_ff;
			IDX_SYSCTL: rdv = 8'((32'(release_mode_select_ff) << SYSCTL_RELEASE_MODE_SELECT_BIT) | (32'(stop_active_ff) << SYSCTL_STOP_BIT));
			IDX_STATUS: rdv = 8'(status_ff);
			IDX_MASK: rdv = 8'(mask_ff);
			IDX_STATE: rdv = {4'h0, release_mode_select_ff, match, stop_s_ff, stop_active_ff};
			default: rdv = 8'h00;
		endcase
		if (!hreadyout_ff) begin
			nxt_hrdata = {24'h000000, rdv};
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			dp_valid_ff <= 1'b0;
			dp_write_ff <= 1'b0;
			dp_idx_ff <= IDX_NONE;
			hreadyout_ff <= 1'b1;
			hrdata_ff <= RDATA_RST;
		end else begin
			dp_valid_ff <= nxt_dp_valid;
			dp_write_ff <= nxt_dp_write;
			dp_idx_ff <= nxt_dp_idx;
			hreadyout_ff <= nxt_hreadyout;
			hrdata_ff <= nxt_hrdata;
		end
	end

	// Register group; write data phase, zero wait
	always_comb begin
		nxt_ctl_lower = ctl_lower_ff;
		nxt_ctl_upper = ctl_upper_ff;
		nxt_pullup = pullup_ff;
		nxt_release_mode_select = release_mode_select_ff;
		nxt_mask = mask_ff;
		if (wr_go) begin
			case (dp_idx_ff)
				IDX_LOWER: nxt_ctl_lower = hwdata[7:0];
				IDX_UPPER: nxt_ctl_upper = hwdata[7:0];
				IDX_PULLUP: nxt_pullup = hwdata[7:0];
				IDX_SYSCTL: nxt_release_mode_select = hwdata[SYSCTL_RELEASE_MODE_SELECT_BIT];
				IDX_MASK: nxt_mask = hwdata[EV_W-1:0];
				default: nxt_release_mode_select = release_mode_select_ff;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctl_lower_ff <= CTL_RST;
			ctl_upper_ff <= CTL_RST;
			pullup_ff <= PULLUP_RST;
			release_mode_select_ff <= RELEASE_MODE_SELECT_RST;
			mask_ff <= EV_RST;
		end else begin
			ctl_lower_ff <= nxt_ctl_lower;
			ctl_upper_ff <= nxt_ctl_upper;
			pullup_ff <= nxt_pullup;
			release_mode_select_ff <= nxt_release_mode_select;
			mask_ff <= nxt_mask;
		end
	end

	// State group; a stop request while already stopped is ignored
	always_comb begin
		nxt_state = state_ff;
		events = '0;
		case (state_ff)
			KWSR_RUN: begin
				if (stop_req) begin
					if (rel_level) begin
						events[EV_REFUSE_BIT] = 1'b1;
					end else begin
						nxt_state = KWSR_STOP;
					end
				end
			end
			KWSR_STOP: begin
				if (release_now) begin
					nxt_state = KWSR_RUN;
					events[EV_WAKE_BIT] = 1'b1;
				end
			end
			default: nxt_state = KWSR_RUN;
		endcase
		nxt_stop_active = (nxt_state == KWSR_STOP);
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_ff <= KWSR_RUN;
			stop_active_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			stop_active_ff <= nxt_stop_active;
		end
	end

	// Status group; write one to clear, a new event in the same cycle wins
	always_comb begin
		nxt_status = status_ff;
		if (wr_go && dp_idx_ff == IDX_STATUS) begin
			nxt_status = status_ff & ~hwdata[EV_W-1:0];
		end
		nxt_status = nxt_status | events;
		nxt_irq = |(status_ff & mask_ff);
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			status_ff <= EV_RST;
			irq_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			irq_ff <= nxt_irq;
		end
	end

	assign hreadyout = hreadyout_ff;
	assign hrdata = hrdata_ff;
	assign hresp = 1'b0;
	// The pull-up register drives the pad pull-ups directly
	assign pullup_en = pullup_ff;
	assign stop_active = stop_active_ff;
	assign irq = irq_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_n);

	upper_write_a: assert property (wr_go && dp_idx_ff == IDX_UPPER |=> ctl_upper_ff == $past(hwdata[7:0]))
		else $error("upper control write lost");
	lower_write_a: assert property (wr_go && dp_idx_ff == IDX_LOWER |=> ctl_lower_ff == $past(hwdata[7:0]))
		else $error("lower control write lost");
	pullup_write_a: assert property (wr_go && dp_idx_ff == IDX_PULLUP |=> pullup_en == $past(hwdata[7:0]))
		else $error("pull-up enables do not follow register");
	stop_refuse_a: assert property (state_ff == KWSR_RUN && stop_req && rel_level |=> !stop_active && status_ff[EV_REFUSE_BIT])
		else $error("stop entered with release source standing");
	stop_enter_a: assert property (state_ff == KWSR_RUN && stop_req && !rel_level |=> stop_active [*2])
		else $error("stop request not taken");
	pin_release_a: assert property (state_ff == KWSR_STOP && release_mode_select_ff && stop_s_ff |=> !stop_active ##1 status_ff[EV_WAKE_BIT])
		else $error("stop-release pin high did not end stop");
	wake_release_a: assert property (state_ff == KWSR_STOP && release_mode_select_ff && match |=> !stop_active)
		else $error("enabled wakeup match did not end stop");
	stop_hold_a: assert property (state_ff == KWSR_STOP && !stop_s_ff && !match |=> stop_active)
		else $error("stop ended without a release source");
	edge_only_a: assert property (state_ff == KWSR_STOP && !release_mode_select_ff && stop_s_ff && stop_d_ff |=> stop_active)
		else $error("edge mode released on a level");
	read_wait_a: assert property (hreadyout && acc && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	irq_level_a: assert property (|(status_ff & mask_ff) |=> irq)
		else $error("interrupt not raised");
	irq_low_a: assert property (!(|(status_ff & mask_ff)) |=> !irq)
		else $error("interrupt raised with no unmasked event");
	write_no_wait_a: assert property (hreadyout && acc && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	read_upper_zero_a: assert property (!hreadyout |=> hrdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	disabled_pins_a: assert property (((ctl_lower_ff | ctl_upper_ff) & 8'h55) == 8'h00 |-> !match)
		else $error("disabled wakeup pin matched");
	edge_release_a: assert property (state_ff == KWSR_STOP && !release_mode_select_ff && stop_rise && !match |=> !stop_active)
		else $error("rising edge did not end stop in edge mode");
	wake_event_a: assert property (state_ff == KWSR_STOP && release_now |=> status_ff[EV_WAKE_BIT])
		else $error("wake event not recorded");
	status_clear_a: assert property (wr_go && dp_idx_ff == IDX_STATUS && events == '0
		|=> (status_ff & $past(hwdata[EV_W-1:0])) == '0)
		else $error("status bit not cleared by write");

	enter_c: cover property (state_ff == KWSR_RUN ##1 stop_active);
	refuse_c: cover property (stop_req && rel_level && state_ff == KWSR_RUN);
	wake_c: cover property (state_ff == KWSR_STOP && release_mode_select_ff && match && !stop_s_ff);
	edge_c: cover property (state_ff == KWSR_STOP && !release_mode_select_ff && stop_rise);
	edge_block_c: cover property (state_ff == KWSR_STOP && !release_mode_select_ff && match && stop_rise);
endmodule : kwsr_top
`default_nettype wire

// File: logic/kwsr_pkg.sv
// Constants and types shared by the key wakeup stop release block
`default_nettype none
package kwsr_pkg;
	localparam int NPINS = 8;
	localparam int SYNC_STAGES = 2;
	localparam int IDX_W = 12;
	// Register indices; the byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_NONE = 12'h000;
	localparam logic [IDX_W-1:0] IDX_LOWER = 12'hFC4;
	localparam logic [IDX_W-1:0] IDX_UPPER = 12'hFC5;
	localparam logic [IDX_W-1:0] IDX_PULLUP = 12'hFC6;
	localparam logic [IDX_W-1:0] IDX_SYSCTL = 12'hFC7;
	localparam logic [IDX_W-1:0] IDX_STATUS = 12'hFC8;
	localparam logic [IDX_W-1:0] IDX_MASK = 12'hFC9;
	localparam logic [IDX_W-1:0] IDX_STATE = 12'hFCA;
	// Field positions
	localparam int SYSCTL_STOP_BIT = 7;
	localparam int SYSCTL_RELEASE_MODE_SELECT_BIT = 5;
	localparam int EV_WAKE_BIT = 0;
	localparam int EV_REFUSE_BIT = 1;
	localparam int EV_W = 2;
	// Values after reset
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] PULLUP_RST = 8'h00;
	localparam logic RELEASE_MODE_SELECT_RST = 1'b0;
	localparam logic [EV_W-1:0] EV_RST = 2'h0;
	localparam logic [31:0] RDATA_RST = 32'h00000000;

	typedef enum logic {KWSR_RUN, KWSR_STOP} kwsr_state_t;

	// Byte address of a register index
	function automatic logic [IDX_W+1:0] kwsr_addr_of(input logic [IDX_W-1:0] idx);
		kwsr_addr_of = {idx, 2'b00};
	endfunction : kwsr_addr_of
endpackage : kwsr_pkg
`default_nettype wire

// File: logic/kwsr_wake_match.sv
// Combinational release-level match of the enabled wakeup pins
`timescale 1ns/1ps
`default_nettype none
module kwsr_wake_match #(
	parameter int NPINS = kwsr_pkg::NPINS
) (
	input wire logic [7:0] ctl_lower,
	input wire logic [7:0] ctl_upper,
	input wire logic [NPINS-1:0] wake_pin,
	output logic match
);
	import kwsr_pkg::*;
	logic [NPINS-1:0] hit;
	// Pure gates, so the same match can be built without a running clock
	for (genvar i = 0; i < NPINS; i++) begin : g_pin
		logic [7:0] ctl;
		assign ctl = (i < 4) ? ctl_lower : ctl_upper;
		// Enabled pin whose level equals its release level
		assign hit[i] = ctl[2*(i%4)] & ~(wake_pin[i] ^ ctl[2*(i%4)+1]);
	end
	assign match = |hit;
endmodule : kwsr_wake_match
`default_nettype wire

// File: test/kwsr_keys.sv
// Model of the keys and drivers on the wakeup and stop-release pins
`timescale 1ns/1ps
`default_nettype none
module kwsr_keys (
	input wire logic clk,
	input wire logic [7:0] drv_en,
	input wire logic [7:0] drv_lvl,
	input wire logic [7:0] pullup_en,
	input wire logic stop_lvl,
	output logic [7:0] wake_pin,
	output logic stop_pin
);
	logic [7:0] junk = 8'h55;
	// A floating pin without pull-up wanders, so no stale level can pass
	always @(posedge clk) junk <= ~junk;
	assign wake_pin = (drv_en & drv_lvl) | (~drv_en & (pullup_en | junk));
	// Kept low except when a stop-pin release is commanded
	assign stop_pin = stop_lvl;
endmodule : kwsr_keys
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the key wakeup stop release block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import kwsr_pkg::*;
	typedef struct {logic [IDX_W-1:0] idx; logic [31:0] wd; logic [31:0] ex;} kwsr_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic stop_lvl = 1'b0;
	logic hreadyout, hresp, stop_pin, stop_active, irq;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [7:0] drv_lvl = 8'h00;
	logic [7:0] wake_pin, pullup_en;
	int err_count = 0;
	int samples_checked = 0;
	kwsr_row_t rows [7] = '{'{IDX_LOWER, 32'h1C3, 32'hC3}, '{IDX_UPPER, 32'h5A, 32'h5A},
		'{IDX_PULLUP, 32'h3C, 32'h3C}, '{IDX_MASK, 32'h3, 32'h3}, '{12'hFCB, 32'hFF, 32'h0},
		'{IDX_LOWER, 32'h0, 32'h0}, '{IDX_UPPER, 32'h0, 32'h0}};
	always #50 clk = ~clk;
	kwsr_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .stop_pin(stop_pin), .wake_pin(wake_pin), .pullup_en(pullup_en),
		.stop_active(stop_active), .irq(irq));
	kwsr_keys keys (.clk(clk), .drv_en(8'hFF), .drv_lvl(drv_lvl), .pullup_en(pullup_en),
		.stop_lvl(stop_lvl), .wake_pin(wake_pin), .stop_pin(stop_pin));
	// One single transfer; ends at a falling edge so outputs are settled
	task automatic bus(input logic [IDX_W-1:0] idx, input logic wr, input logic [31:0] wd);
		@(posedge clk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, wr, 18'h0, idx, 2'b00};
		do @(posedge clk); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		@(negedge clk);
	endtask : bus
	task automatic chk(input logic [31:0] got, input logic [31:0] ex);
		samples_checked++;
		if (got !== ex) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, ex);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask : settle
	// Bounded wait for the release of STOP
	task automatic wait_free;
		int n;
		n = 0;
		while (stop_active !== 1'b0 && n < 8) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_free
	task final_report;
		$display("Counts: %0d checked, %0d mismatches", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report
	initial begin
		#500000;
		err_count++;
		final_report;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		settle(4);
		chk(32'({pullup_en, stop_active, irq, hresp}), 32'h0);
		for (int i = 0; i < 7; i++) begin
			bus(IDX_LOWER + 12'(i), 1'b0, 32'h0);
			chk(rd, 32'h0);
		end
		$display("Test reset values done");
		foreach (rows[i]) begin
			bus(rows[i].idx, 1'b1, rows[i].wd);
			bus(rows[i].idx, 1'b0, 32'h0);
			chk(rd, rows[i].ex);
		end
		chk(32'(pullup_en), 32'h3C);
		$display("Test register table done");
		bus(IDX_SYSCTL, 1'b1, 32'hA0);
		chk(32'(stop_active), 32'h1);
		@(posedge clk) drv_lvl <= 8'hFF;
		settle(8);
		chk(32'(stop_active), 32'h1);
		@(posedge clk) stop_lvl <= 1'b1;
		wait_free;
		chk(32'(stop_active), 32'h0);
		settle(1);
		chk(32'(irq), 32'h1);
		@(posedge clk) stop_lvl <= 1'b0;
		bus(IDX_STATUS, 1'b0, 32'h0);
		chk(rd, 32'h1);
		bus(IDX_STATUS, 1'b1, 32'h1);
		settle(2);
		chk(32'(irq), 32'h0);
		$display("Test stop pin release done");
		for (int k = 0; k < 16; k++) begin
			int p;
			logic lv;
			logic [IDX_W-1:0] ci;
			p = k / 2;
			lv = k[0];
			ci = (p < 4) ? IDX_LOWER : IDX_UPPER;
			@(posedge clk) drv_lvl <= lv ? 8'h00 : 8'hFF;
			bus(ci, 1'b1, 32'({lv, 1'b1}) << (2 * (p % 4)));
			settle(3);
			bus(IDX_SYSCTL, 1'b1, 32'hA0);
			chk(32'(stop_active), 32'h1);
			@(posedge clk) drv_lvl <= ~drv_lvl;
			wait_free;
			chk(32'(stop_active), 32'h0);
			bus(ci, 1'b1, 32'h0);
		end
		$display("Test wake pin levels done");
		@(posedge clk) drv_lvl <= 8'h01;
		bus(IDX_LOWER, 1'b1, 32'h3);
		bus(IDX_STATUS, 1'b1, 32'h3);
		settle(3);
		bus(IDX_SYSCTL, 1'b1, 32'hA0);
		chk(32'(stop_active), 32'h0);
		bus(IDX_STATUS, 1'b0, 32'h0);
		chk(rd, 32'h2);
		bus(IDX_MASK, 1'b1, 32'h0);
		settle(2);
		chk(32'(irq), 32'h0);
		bus(IDX_MASK, 1'b1, 32'h2);
		settle(2);
		chk(32'(irq), 32'h1);
		bus(IDX_STATUS, 1'b1, 32'h2);
		settle(2);
		chk(32'(irq), 32'h0);
		bus(IDX_LOWER, 1'b1, 32'h0);
		$display("Test refusal and interrupt done");
		bus(IDX_SYSCTL, 1'b1, 32'h80);
		bus(IDX_SYSCTL, 1'b0, 32'h0);
		chk(rd, 32'h80);
		@(posedge clk) stop_lvl <= 1'b1;
		wait_free;
		chk(32'(stop_active), 32'h0);
		@(posedge clk) stop_lvl <= 1'b0;
		$display("Test edge release done");
		bus(IDX_LOWER, 1'b1, 32'h1);
		bus(IDX_SYSCTL, 1'b1, 32'h80);
		chk(32'(stop_active), 32'h1);
		@(posedge clk) drv_lvl <= 8'h00;
		settle(4);
		@(posedge clk) stop_lvl <= 1'b1;
		settle(6);
		chk(32'(stop_active), 32'h1);
		bus(IDX_STATE, 1'b0, 32'h0);
		chk(rd, 32'h7);
		bus(IDX_SYSCTL, 1'b1, 32'h20);
		wait_free;
		chk(32'(stop_active), 32'h0);
		@(posedge clk) stop_lvl <= 1'b0;
		bus(IDX_LOWER, 1'b1, 32'h0);
		$display("Test edge blocking done");
		bus(IDX_UPPER, 1'b1, 32'hFF);
		@(posedge clk) rst_n <= 1'b0;
		settle(2);
		@(posedge clk) rst_n <= 1'b1;
		settle(4);
		bus(IDX_UPPER, 1'b0, 32'h0);
		chk(rd, 32'h0);
		chk(32'(pullup_en), 32'h0);
		$display("Test second reset done");
		final_report;
	end
endmodule : tb
`default_nettype wire
